//--- hw/risd_top.sv
// What this block does
// - Six program select bits weigh 1..32; value N starts main function N.
// - Remote commands are taken only while remote accept output is on.
// - Reset command turns all general outputs off, reinitialises robots.
// - Pause setting 0: any low-power edge stops tasks and forces low; one edge sets high power ok, but forced low clears high power set.
// - Pause setting 1: entering low power pauses; leaving it allows high.
// - Robot select strobe latches the robot governing status flags.
// - After start the latched robot selection means all robots.
// - Five robot select bits weigh 1..16; zero means all robots.
// - Motor-on request also reinitialises the addressed robot's parameters.
// - Alarm clear removes only the alarm chosen by alarm select.
// - Four alarm select bits; 1 battery, 3 grease, others unassigned.
module risd_top #(
    parameter int NUM_ROBOTS = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq_o,
    input wire logic start_input_i,
    input wire logic reset_input_i,
    input wire logic motor_on_request_i,
    input wire logic robot_select_strobe_i,
    input wire logic alarm_clear_input_i,
    input wire logic high_power_command_i,
    input wire logic forced_low_power_input_i,
    input wire logic [5:0] program_select_i,
    input wire logic [4:0] robot_select_i,
    input wire logic [3:0] alarm_select_i,
    input wire logic [15:0] alarm_raise_i,
    output logic remote_accept_output_o,
    output logic start_pulse_o,
    output logic [5:0] start_program_o,
    output logic io_all_off_o,
    output logic [NUM_ROBOTS:0] robot_param_init_o,
    output logic [4:0] status_robot_o,
    output logic [15:0] alarm_active_o,
    output logic stop_all_o,
    output logic pause_all_o,
    output logic force_low_o,
    output logic high_power_ok_o,
    output logic high_power_set_o
);
    localparam int NEV = risd_pkg::RISD_NUM_EV;

    initial begin
        if (NUM_ROBOTS < 1 || NUM_ROBOTS > 16)
            $error("risd_top NUM_ROBOTS must be 1 to 16.");
    end

    // Synchronised command inputs: start, reset, motor, robot sel, alarm, hp.
    logic [5:0] cmd_rise;
    logic flp_lvl;
    logic flp_rise;
    logic flp_fall;
    logic [5:0] prog_val;
    logic [4:0] robot_val;
    logic [3:0] alarm_val;
    logic [15:0] alarm_hot;
    logic [15:0] raise_lvl;

    risd_edge #(.WIDTH(6)) u_cmd (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i({high_power_command_i, alarm_clear_input_i,
                  robot_select_strobe_i, motor_on_request_i,
                  reset_input_i, start_input_i}),
        .level_o(),
        .rise_o(cmd_rise),
        .fall_o()
    );

    risd_edge #(.WIDTH(1)) u_flp (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i(forced_low_power_input_i),
        .level_o(flp_lvl),
        .rise_o(flp_rise),
        .fall_o(flp_fall)
    );

    risd_field #(.WIDTH(6)) u_prog (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .field_i(program_select_i),
        .value_o(prog_val),
        .onehot_o()
    );

    risd_field #(.WIDTH(5)) u_robot (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .field_i(robot_select_i),
        .value_o(robot_val),
        .onehot_o()
    );

    risd_field #(.WIDTH(4)) u_alarm (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .field_i(alarm_select_i),
        .value_o(alarm_val),
        .onehot_o(alarm_hot)
    );

    risd_edge #(.WIDTH(16)) u_raise (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i(alarm_raise_i),
        .level_o(raise_lvl),
        .rise_o(),
        .fall_o()
    );

    // Maps a robot number to a parameter-init vector; bit 0 means all.
    function automatic logic [NUM_ROBOTS:0] risd_robot_vec(
        input logic [4:0] num
    );
        logic [NUM_ROBOTS:0] v;
        v = '0;
        if (num == risd_pkg::RISD_ROBOT_ALL)
            v = '1;
        else if (32'(num) <= NUM_ROBOTS)
            v[num] = 1'b1;
        return v;
    endfunction

    // Software-held control bits.
    logic [31:0] ctrl;
    logic [31:0] next_ctrl;
    logic [NEV-1:0] irq_stat;
    logic [NEV-1:0] next_irq_stat;
    logic [NEV-1:0] irq_mask;
    logic [NEV-1:0] next_irq_mask;
    logic accept;
    logic low_when_off;
    logic pause_on_chg;

    assign accept = ctrl[risd_pkg::RISD_CTRL_REMOTE_ACCEPT];
    assign low_when_off = ctrl[risd_pkg::RISD_CTRL_LOW_WHEN_OFF];
    assign pause_on_chg = ctrl[risd_pkg::RISD_CTRL_PAUSE_ON_CHG];

    // Command decode state.
    logic start_pulse;
    logic next_start_pulse;
    logic [5:0] start_prog;
    logic [5:0] next_start_prog;
    logic io_off;
    logic next_io_off;
    logic [NUM_ROBOTS:0] rinit;
    logic [NUM_ROBOTS:0] next_rinit;
    logic [4:0] status_robot;
    logic [4:0] next_status_robot;
    logic [15:0] alarms;
    logic [15:0] next_alarms;
    logic stop_all;
    logic next_stop_all;
    logic pause_all;
    logic next_pause_all;
    logic force_low;
    logic next_force_low;
    logic hp_ok;
    logic next_hp_ok;
    logic hp_set;
    logic next_hp_set;
    logic [NEV-1:0] ev;
    logic flp_enter;
    logic flp_leave;

    // Which forced-low-power edge enters the low-power condition.
    assign flp_enter = low_when_off ? flp_fall : flp_rise;
    assign flp_leave = low_when_off ? flp_rise : flp_fall;

    // Commands need remote accept; the forced-low input is always honoured.
    always_comb begin
        next_start_pulse = 1'b0;
        next_start_prog = start_prog;
        next_io_off = 1'b0;
        next_rinit = '0;
        next_status_robot = status_robot;
        next_alarms = alarms | raise_lvl;
        next_stop_all = 1'b0;
        next_pause_all = pause_all;
        next_force_low = force_low;
        next_hp_ok = hp_ok;
        next_hp_set = hp_set;
        ev = '0;
        if (accept && cmd_rise[0]) begin
            next_start_pulse = 1'b1;
            next_start_prog = prog_val;
            ev[risd_pkg::RISD_EV_START] = 1'b1;
        end
        if (accept && cmd_rise[1]) begin
            next_io_off = 1'b1;
            next_rinit = '1;
            next_hp_set = 1'b0;
            ev[risd_pkg::RISD_EV_RESET] = 1'b1;
        end
        if (accept && cmd_rise[2]) begin
            next_rinit = next_rinit | risd_robot_vec(robot_val);
            ev[risd_pkg::RISD_EV_MOTOR_ON] = 1'b1;
        end
        if (accept && cmd_rise[3]) begin
            next_status_robot = robot_val;
            ev[risd_pkg::RISD_EV_ROBOT_SEL] = 1'b1;
        end
        if (accept && cmd_rise[4]) begin
            // A new raise in the same cycle outlives the clear.
            next_alarms = (alarms & ~alarm_hot) | raise_lvl;
            ev[risd_pkg::RISD_EV_ALARM_CLR] = 1'b1;
        end
        if (flp_rise || flp_fall) begin
            if (!pause_on_chg) begin
                next_stop_all = 1'b1;
                next_force_low = 1'b1;
                next_hp_ok = flp_leave;
            end else if (flp_enter) begin
                next_pause_all = 1'b1;
                next_force_low = 1'b1;
                next_hp_ok = 1'b0;
            end else begin
                next_pause_all = 1'b0;
                next_force_low = 1'b0;
                next_hp_ok = 1'b1;
            end
            ev[risd_pkg::RISD_EV_LOW_POWER] = 1'b1;
        end
        if (next_force_low)
            next_hp_set = 1'b0;
        if (accept && cmd_rise[5]) begin
            if (hp_ok) begin
                next_hp_set = 1'b1;
                ev[risd_pkg::RISD_EV_HP_ACCEPT] = 1'b1;
            end else begin
                ev[risd_pkg::RISD_EV_HP_REJECT] = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            start_pulse <= 1'b0;
            start_prog <= '0;
            io_off <= 1'b0;
            rinit <= '0;
            status_robot <= risd_pkg::RISD_ROBOT_ALL;
            alarms <= '0;
            stop_all <= 1'b0;
            pause_all <= 1'b0;
            force_low <= 1'b0;
            hp_ok <= 1'b1;
            hp_set <= 1'b0;
        end else begin
            start_pulse <= next_start_pulse;
            start_prog <= next_start_prog;
            io_off <= next_io_off;
            rinit <= next_rinit;
            status_robot <= next_status_robot;
            alarms <= next_alarms;
            stop_all <= next_stop_all;
            pause_all <= next_pause_all;
            force_low <= next_force_low;
            hp_ok <= next_hp_ok;
            hp_set <= next_hp_set;
        end
    end

    // Wishbone slave: one wait state, then ack for a single cycle.
    risd_pkg::risd_bus_t bus_st;
    risd_pkg::risd_bus_t next_bus_st;
    logic [31:0] rdata;
    logic [31:0] next_rdata;
    logic irq;
    logic next_irq;
    logic bus_go;
    logic stat_rd;

    assign bus_go = wb_cyc_i && wb_stb_i && (bus_st == risd_pkg::RISD_BUS_IDLE);
    assign stat_rd = bus_go && !wb_we_i &&
                     (wb_adr_i[7:0] == risd_pkg::RISD_OFF_IRQ_STAT);

    // Register writes honour byte lanes; unmapped addresses read zero.
    always_comb begin
        next_bus_st = bus_st;
        next_rdata = '0;
        next_ctrl = ctrl;
        next_irq_mask = irq_mask;
        // A read clears status, but an event in that cycle still sets it.
        next_irq_stat = (stat_rd ? '0 : irq_stat) | ev;
        case (bus_st)
            risd_pkg::RISD_BUS_IDLE: begin
                if (bus_go) begin
                    next_bus_st = risd_pkg::RISD_BUS_ACK;
                    if (wb_we_i) begin
                        if (wb_adr_i[7:0] == risd_pkg::RISD_OFF_CTRL &&
                            wb_sel_i[0])
                            next_ctrl[7:0] = wb_dat_i[7:0];
                        if (wb_adr_i[7:0] == risd_pkg::RISD_OFF_IRQ_MASK &&
                            wb_sel_i[0])
                            next_irq_mask = wb_dat_i[NEV-1:0];
                    end else begin
                        case (wb_adr_i[7:0])
                            risd_pkg::RISD_OFF_CTRL: next_rdata = ctrl;
                            risd_pkg::RISD_OFF_STATUS: next_rdata =
                                {26'h0, hp_set, hp_ok, force_low,
                                 pause_all, accept, flp_lvl};
                            risd_pkg::RISD_OFF_IRQ_STAT:
                                next_rdata = {24'h0, irq_stat};
                            risd_pkg::RISD_OFF_IRQ_MASK:
                                next_rdata = {24'h0, irq_mask};
                            risd_pkg::RISD_OFF_ALARM:
                                next_rdata = {16'h0, alarms};
                            risd_pkg::RISD_OFF_SEL: next_rdata =
                                {6'h0, status_robot, start_prog, prog_val,
                                 robot_val, alarm_val};
                            default: next_rdata = '0;
                        endcase
                    end
                end
            end
            risd_pkg::RISD_BUS_ACK: next_bus_st = risd_pkg::RISD_BUS_IDLE;
            default: next_bus_st = risd_pkg::RISD_BUS_IDLE;
        endcase
        next_irq = |(next_irq_stat & next_irq_mask);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_st <= risd_pkg::RISD_BUS_IDLE;
            rdata <= '0;
            ctrl <= risd_pkg::RISD_CTRL_RESET;
            irq_stat <= '0;
            irq_mask <= '0;
            irq <= 1'b0;
        end else begin
            bus_st <= next_bus_st;
            rdata <= next_rdata;
            ctrl <= next_ctrl;
            irq_stat <= next_irq_stat;
            irq_mask <= next_irq_mask;
            irq <= next_irq;
        end
    end

    // All outputs come straight from flip-flops, except wb_ack_o, which is decoded from bus_st.
    assign wb_dat_o = rdata;
    assign wb_ack_o = (bus_st == risd_pkg::RISD_BUS_ACK);
    assign irq_o = irq;
    assign remote_accept_output_o = ctrl[risd_pkg::RISD_CTRL_REMOTE_ACCEPT];
    assign start_pulse_o = start_pulse;
    assign start_program_o = start_prog;
    assign io_all_off_o = io_off;
    assign robot_param_init_o = rinit;
    assign status_robot_o = status_robot;
    assign alarm_active_o = alarms;
    assign stop_all_o = stop_all;
    assign pause_all_o = pause_all;
    assign force_low_o = force_low;
    assign high_power_ok_o = hp_ok;
    assign high_power_set_o = hp_set;
endmodule

//--- hw/risd_pkg.sv
package risd_pkg;

    // Register byte offsets on the bus.
    localparam logic [7:0] RISD_OFF_CTRL = 8'h00;
    localparam logic [7:0] RISD_OFF_STATUS = 8'h04;
    localparam logic [7:0] RISD_OFF_IRQ_STAT = 8'h08;
    localparam logic [7:0] RISD_OFF_IRQ_MASK = 8'h0C;
    localparam logic [7:0] RISD_OFF_ALARM = 8'h10;
    localparam logic [7:0] RISD_OFF_SEL = 8'h14;

    // Control register fields.
    localparam int RISD_CTRL_LOW_WHEN_OFF = 0;
    localparam int RISD_CTRL_PAUSE_ON_CHG = 1;
    localparam int RISD_CTRL_REMOTE_ACCEPT = 2;
    localparam logic [31:0] RISD_CTRL_RESET = 32'h0000_0000;

    // Interrupt status bit positions.
    localparam int RISD_EV_START = 0;
    localparam int RISD_EV_RESET = 1;
    localparam int RISD_EV_MOTOR_ON = 2;
    localparam int RISD_EV_ROBOT_SEL = 3;
    localparam int RISD_EV_ALARM_CLR = 4;
    localparam int RISD_EV_LOW_POWER = 5;
    localparam int RISD_EV_HP_REJECT = 6;
    localparam int RISD_EV_HP_ACCEPT = 7;
    localparam int RISD_NUM_EV = 8;

    // Field widths of the select inputs.
    localparam int RISD_PROG_W = 6;
    localparam int RISD_ROBOT_W = 5;
    localparam int RISD_ALARM_W = 4;
    localparam int RISD_NUM_ALARMS = 16;

    // Reset value of the latched robot selection: zero means all robots.
    localparam logic [4:0] RISD_ROBOT_ALL = 5'h00;

    // Alarm numbers with a defined meaning.
    localparam logic [3:0] RISD_ALARM_BATTERY = 4'h1;
    localparam logic [3:0] RISD_ALARM_GREASE = 4'h3;

    // Wishbone slave states.
    typedef enum logic [1:0] {
        RISD_BUS_IDLE = 2'b01,
        RISD_BUS_ACK = 2'b10
    } risd_bus_t;

endpackage

//--- hw/risd_edge.sv
// Two-stage synchroniser followed by rise and fall detection.
module risd_edge #(
    parameter int WIDTH = 1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] level_o,
    output logic [WIDTH-1:0] rise_o,
    output logic [WIDTH-1:0] fall_o
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
    logic [WIDTH-1:0] prev;

    initial begin
        if (WIDTH < 1) $error("risd_edge needs WIDTH of at least one.");
    end

    // The first stage only feeds the second, so no gate sees metastability.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta <= '0;
            sync <= '0;
            prev <= '0;
        end else begin
            meta <= async_i;
            sync <= meta;
            prev <= sync;
        end
    end

    assign level_o = sync;
    assign rise_o = sync & ~prev;
    assign fall_o = ~sync & prev;
endmodule

//--- hw/risd_field.sv
// Synchronises a select field and decodes it to a one-hot vector.
module risd_field #(
    parameter int WIDTH = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] field_i,
    output logic [WIDTH-1:0] value_o,
    output logic [(1<<WIDTH)-1:0] onehot_o
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;

    initial begin
        if (WIDTH < 1 || WIDTH > 8) $error("risd_field WIDTH out of range.");
    end

    // Bits are plain binary weights, so the value needs no remapping.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta <= '0;
            sync <= '0;
        end else begin
            meta <= field_i;
            sync <= meta;
        end
    end

    assign value_o = sync;

    genvar g;
    generate
        for (g = 0; g < (1 << WIDTH); g++) begin : g_dec
            assign onehot_o[g] = (sync == WIDTH'(g));
        end
    endgenerate
endmodule

//--- sim/risd_plc_model.sv
// Stand-in for the external master; pins start low to avoid a stray edge.
module risd_plc_model (
    input wire logic clk_i,
    output logic [5:0] cmd_o = 6'h00,
    output logic flp_o = 1'b0,
    output logic [5:0] prog_o = 6'h00,
    output logic [4:0] robot_o = 5'h00,
    output logic [3:0] alarm_o = 4'h0
);
    timeunit 1ns;
    timeprecision 100ps;

    // Fields are binary weighted, bit 0 weighing one, settled before a strobe.
    task automatic set_sel(input logic [5:0] p, input logic [4:0] r,
            input logic [3:0] a);
        @(posedge clk_i);
        prog_o <= p;
        robot_o <= r;
        alarm_o <= a;
        repeat (4) @(posedge clk_i);
    endtask

    // One command at a time, so a restart never overlaps a start.
    task automatic pulse_cmd(input int which);
        @(posedge clk_i);
        cmd_o[which] <= 1'b1;
        repeat (4) @(posedge clk_i);
        cmd_o[which] <= 1'b0;
        repeat (6) @(posedge clk_i);
    endtask

    // The forced low power level is held long enough to pass the synchroniser.
    task automatic set_flp(input logic level);
        @(posedge clk_i);
        flp_o <= level;
        repeat (6) @(posedge clk_i);
    endtask
endmodule

//--- sim/risd_props.sv
// Port-level checks of the remote input decoder.
module risd_props #(
    parameter int NUM_ROBOTS = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_ack_o,
    input wire logic remote_accept_output_o,
    input wire logic start_input_i,
    input wire logic reset_input_i,
    input wire logic motor_on_request_i,
    input wire logic robot_select_strobe_i,
    input wire logic alarm_clear_input_i,
    input wire logic [5:0] program_select_i,
    input wire logic [4:0] robot_select_i,
    input wire logic [3:0] alarm_select_i,
    input wire logic start_pulse_o,
    input wire logic [5:0] start_program_o,
    input wire logic io_all_off_o,
    input wire logic [NUM_ROBOTS:0] robot_param_init_o,
    input wire logic [4:0] status_robot_o,
    input wire logic [15:0] alarm_active_o,
    input wire logic pause_all_o,
    input wire logic force_low_o,
    input wire logic high_power_ok_o
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [NUM_ROBOTS:0] ONE_ROBOT = {{NUM_ROBOTS{1'b0}}, 1'b1};

    // One clock domain, so clocking and reset gating are stated once.
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // Commands reach the outputs three edges after the pin rises.
    property p_ack_once;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_once: assert property (p_ack_once)
        else $error("bus ack lasted more than one cycle");
    property p_start;
        $rose(start_input_i) && remote_accept_output_o |-> ##3
            start_pulse_o && start_program_o == $past(program_select_i, 3);
    endproperty
    a_start: assert property (p_start)
        else $error("start did not launch the selected program");
    property p_reset_cmd;
        $rose(reset_input_i) && remote_accept_output_o |-> ##3
            io_all_off_o && (&robot_param_init_o);
    endproperty
    a_reset_cmd: assert property (p_reset_cmd)
        else $error("reset command missed outputs off or parameter init");
    property p_robot_latch;
        $rose(robot_select_strobe_i) && remote_accept_output_o |-> ##3
            status_robot_o == $past(robot_select_i, 3);
    endproperty
    a_robot_latch: assert property (p_robot_latch)
        else $error("robot selection not latched");
    property p_robot_default;
        $fell(rst_i) |-> status_robot_o == 5'h00 && high_power_ok_o;
    endproperty
    a_robot_default: assert property (p_robot_default)
        else $error("robot selection not all robots after start");
    property p_motor;
        $rose(motor_on_request_i) && remote_accept_output_o |-> ##3
            robot_param_init_o == (($past(robot_select_i, 3) == 5'h00) ?
            ~ONE_ROBOT | ONE_ROBOT : ONE_ROBOT << $past(robot_select_i, 3));
    endproperty
    a_motor: assert property (p_motor)
        else $error("motor on did not init the addressed robot");
    property p_alarm;
        $rose(alarm_clear_input_i) && remote_accept_output_o |-> ##3
            alarm_active_o == ($past(alarm_active_o) &
            ~(16'h0001 << $past(alarm_select_i, 3)));
    endproperty
    a_alarm: assert property (p_alarm)
        else $error("alarm clear touched the wrong alarm");
    property p_pause;
        pause_all_o |-> force_low_o && !high_power_ok_o;
    endproperty
    a_pause: assert property (p_pause)
        else $error("paused without forced low power");
endmodule

bind risd_top risd_props #(.NUM_ROBOTS(NUM_ROBOTS)) i_props (.*);

//--- sim/testbench.sv
`define CHK(what, exp, got) \
    begin \
        check_count++; \
        if ((got) !== (exp)) begin \
            miscompares++; \
            $display("MISMATCH %s expected %0h seen %0h", what, exp, got); \
        end \
    end

// Self-checking bench for the remote input decoder.
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [31:0] wb_adr_i = '0, wb_dat_i = '0, rd;
    logic [3:0] wb_sel_i = 4'h0, sel = 4'hF;
    logic wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
    logic [15:0] alarm_raise_i = 16'h0000, alarm_active_o;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, irq_o, remote_accept_output_o, start_pulse_o, io_all_off_o;
    logic stop_all_o, pause_all_o, force_low_o, high_power_ok_o;
    logic high_power_set_o, flp, lwo, pse;
    logic [5:0] start_program_o, last_prog, cmd, prog;
    logic [16:0] robot_param_init_o, param_seen = 17'h00000;
    logic [4:0] status_robot_o, robot;
    logic [3:0] alarm;
    int miscompares = 0, check_count = 0, n_start = 0, n_off = 0, n_stop = 0;
    logic [5:0] progs [8] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h3C, 6'h3D,
        6'h3E, 6'h3F};

    risd_plc_model plc (.clk_i(clk_i), .cmd_o(cmd), .flp_o(flp),
        .prog_o(prog), .robot_o(robot), .alarm_o(alarm));
    risd_top #(.NUM_ROBOTS(16)) i_dut (.*, .start_input_i(cmd[0]),
        .reset_input_i(cmd[1]), .motor_on_request_i(cmd[2]),
        .robot_select_strobe_i(cmd[3]), .alarm_clear_input_i(cmd[4]),
        .high_power_command_i(cmd[5]), .forced_low_power_input_i(flp),
        .program_select_i(prog), .robot_select_i(robot),
        .alarm_select_i(alarm));

    // Free-running 100 MHz clock.
    always #5 clk_i = ~clk_i;

    // Pulses last one cycle, so they are tallied here rather than polled.
    always @(posedge clk_i) begin
        if (start_pulse_o === 1'b1) begin
            n_start++;
            last_prog = start_program_o;
        end
        if (io_all_off_o === 1'b1) n_off++;
        if (stop_all_o === 1'b1) n_stop++;
        param_seen = param_seen | robot_param_init_o;
    end

    // One classic cycle; the request is held until ack is seen at an edge.
    task automatic wb_cycle(input logic [7:0] a, input logic we,
            input logic [31:0] d);
        int n = 0;
        @(posedge clk_i);
        wb_adr_i <= {24'h000000, a};
        wb_we_i <= we;
        wb_dat_i <= d;
        wb_sel_i <= sel;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        if (n >= 50) miscompares++;
    endtask

    task automatic do_reset();
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // A hang counts as a failure and ends the run through the same exit.
    initial begin
        repeat (6000) @(posedge clk_i);
        miscompares++;
        close_out();
    end

    // Main sequence of tests.
    initial begin
        do_reset();
        wb_cycle(risd_pkg::RISD_OFF_CTRL, 1'b0, 32'h00000000);
        `CHK("ctrl reset", 32'h00000000, rd)
        wb_cycle(8'h18, 1'b0, 32'h00000000);
        `CHK("unmapped read", 32'h00000000, rd)
        `CHK("robot sel default", 5'h00, status_robot_o)
        `CHK("hp ok default", 1'b1, high_power_ok_o)
        plc.set_sel(6'h2A, 5'h0A, 4'hC);
        plc.pulse_cmd(0);
        `CHK("start while closed", 0, n_start)
        wb_cycle(risd_pkg::RISD_OFF_IRQ_STAT, 1'b0, 32'h00000000);
        `CHK("no event while closed", 32'h00000000, rd)
        $display("test reset_and_gate done");
        wb_cycle(risd_pkg::RISD_OFF_IRQ_MASK, 1'b1, 32'h000000FF);
        wb_cycle(risd_pkg::RISD_OFF_CTRL, 1'b1, 32'h00000004);
        `CHK("accept output", 1'b1, remote_accept_output_o)
        sel = 4'hE;
        wb_cycle(risd_pkg::RISD_OFF_CTRL, 1'b1, 32'h00000000);
        sel = 4'hF;
        `CHK("lane 0 off", 1'b1, remote_accept_output_o)
        for (int i = 0; i < 8; i++) begin
            plc.set_sel(progs[i], 5'h00, 4'h0);
            plc.pulse_cmd(0);
            `CHK("program", progs[i], last_prog)
            `CHK("start count", i + 1, n_start)
        end
        `CHK("irq raised", 1'b1, irq_o)
        wb_cycle(risd_pkg::RISD_OFF_IRQ_STAT, 1'b0, 32'h00000000);
        `CHK("start event", 1'b1, rd[risd_pkg::RISD_EV_START])
        wb_cycle(risd_pkg::RISD_OFF_IRQ_STAT, 1'b0, 32'h00000000);
        `CHK("read clears", 32'h00000000, rd)
        `CHK("irq dropped", 1'b0, irq_o)
        $display("test program_select done");
        wb_cycle(risd_pkg::RISD_OFF_IRQ_MASK, 1'b1, 32'h00000000);
        plc.set_sel(6'h00, 5'h10, 4'h0);
        plc.pulse_cmd(3);
        `CHK("robot latched", 5'h10, status_robot_o)
        `CHK("masked irq", 1'b0, irq_o)
        plc.set_sel(6'h00, 5'h0F, 4'h0);
        param_seen = 17'h00000;
        plc.pulse_cmd(2);
        `CHK("motor init", 17'h08000, param_seen)
        `CHK("robot kept", 5'h10, status_robot_o)
        plc.set_sel(6'h00, 5'h00, 4'h0);
        param_seen = 17'h00000;
        plc.pulse_cmd(2);
        `CHK("motor init all", 17'h1FFFF, param_seen)
        wb_cycle(risd_pkg::RISD_OFF_SEL, 1'b0, 32'h00000000);
        `CHK("sel reg", 32'h021F8000, rd)
        param_seen = 17'h00000;
        plc.pulse_cmd(1);
        `CHK("outputs off", 1, n_off)
        `CHK("reset init all", 17'h1FFFF, param_seen)
        $display("test robots done");
        @(posedge clk_i);
        alarm_raise_i <= 16'hFFFF;
        repeat (2) @(posedge clk_i);
        alarm_raise_i <= 16'h0000;
        repeat (5) @(posedge clk_i);
        `CHK("alarms raised", 16'hFFFF, alarm_active_o)
        plc.set_sel(6'h00, 5'h00, 4'h3);
        plc.pulse_cmd(4);
        `CHK("grease cleared", 16'hFFF7, alarm_active_o)
        wb_cycle(risd_pkg::RISD_OFF_ALARM, 1'b1, 32'h0000FFFF);
        wb_cycle(risd_pkg::RISD_OFF_ALARM, 1'b0, 32'h00000000);
        `CHK("alarm reg read only", 16'hFFF7, rd[15:0])
        plc.set_sel(6'h00, 5'h00, 4'h1);
        plc.pulse_cmd(4);
        `CHK("battery cleared", 16'hFFF5, alarm_active_o)
        $display("test alarms done");
        for (int m = 0; m < 4; m++) begin
            lwo = m[0];
            pse = m[1];
            do_reset();
            wb_cycle(risd_pkg::RISD_OFF_CTRL, 1'b1, {29'h0, 1'b1, pse, lwo});
            n_stop = 0;
            plc.set_flp(1'b1);
            `CHK("low rise", pse ? !lwo : 1'b1, force_low_o)
            `CHK("hp ok rise", lwo, high_power_ok_o)
            `CHK("pause rise", pse & !lwo, pause_all_o)
            plc.set_flp(1'b0);
            `CHK("low fall", pse ? lwo : 1'b1, force_low_o)
            `CHK("hp ok fall", !lwo, high_power_ok_o)
            `CHK("pause fall", pse & lwo, pause_all_o)
            `CHK("stops", pse ? 0 : 2, n_stop)
            plc.pulse_cmd(5);
            wb_cycle(risd_pkg::RISD_OFF_IRQ_STAT, 1'b0, 32'h00000000);
            `CHK("hp verdict", lwo ? 2'b01 : 2'b10, rd[7:6])
            `CHK("hp set", pse & !lwo, high_power_set_o)
        end
        $display("test forced_low done");
        close_out();
    end
endmodule
